// ==== pkg/alhg_defs.svh ====
// Register offsets, field positions, reset values and ramp constants of the axis guard
`ifndef ALHG_DEFS_SVH
`define ALHG_DEFS_SVH

`define ALHG_AW            8
`define ALHG_OFF_CTRL      8'h00
`define ALHG_OFF_CMD       8'h04
`define ALHG_OFF_STATUS    8'h08
`define ALHG_OFF_ELAP_LO   8'h0C
`define ALHG_OFF_ELAP_HI   8'h10
`define ALHG_OFF_JOG_PER   8'h14
`define ALHG_OFF_HOME_PER  8'h18
`define ALHG_OFF_IRQ_STAT  8'h1C
`define ALHG_OFF_IRQ_MASK  8'h20

`define ALHG_CTRL_LIM_INV  0
`define ALHG_CTRL_HOME_INV 1
`define ALHG_CTRL_NEAR_INV 2
`define ALHG_CTRL_DIR_SWAP 3
`define ALHG_CTRL_RST      4'h0

`define ALHG_CMD_JOG_FWD   0
`define ALHG_CMD_JOG_REV   1
`define ALHG_CMD_HOME      2
`define ALHG_CMD_STOP      3

`define ALHG_EV_START_ERR  0
`define ALHG_EV_RUN_ERR    1
`define ALHG_EV_HOME_DONE  2
`define ALHG_EV_MOVE_DONE  3

`define ALHG_START_PER     16'h1000
`define ALHG_RAMP_STEP     16'h0010
`define ALHG_JOG_PER_RST   16'h0400
`define ALHG_HOME_PER_RST  16'h0800

`define ALHG_RESP_OKAY     2'h0
`define ALHG_RESP_SLVERR   2'h2

`endif

// ==== pkg/alhg_pkg.sv ====
// Types shared by the axis limit and home guard
package alhg_pkg;

  typedef enum logic [2:0] {
    ALHG_IDLE      = 3'b000,
    ALHG_RUN       = 3'b001,
    ALHG_DECEL     = 3'b010,
    ALHG_HOME_FAST = 3'b011,
    ALHG_HOME_SLOW = 3'b100
  } alhg_state_t;

endpackage

// ==== design/alhg_sync.sv ====
// Two-flop synchroniser for the four switch inputs
`timescale 1ns/1ps
module alhg_sync (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] async_i,
  output logic      [3:0] sync_o
);

  logic [3:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 4'h0;
      sync_o <= 4'h0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // alhg_sync

// ==== design/alhg_pulse_gen.sv ====
// Step pulse generator with a linear period ramp toward a target period
`timescale 1ns/1ps
`include "alhg_defs.svh"
module alhg_pulse_gen (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic [15:0] tgt_per_i,
  output logic             step_o,
  output logic             floor_o
);

  logic [15:0] period_q;
  logic [15:0] cnt_q;
  logic [15:0] period_d;

  // Moves one ramp step toward the target, never past it
  function automatic logic [15:0] ramp(input logic [15:0] p, input logic [15:0] t);
    if (p > t)
      ramp = ((p - t) > `ALHG_RAMP_STEP) ? p - `ALHG_RAMP_STEP : t;
    else if (p < t)
      ramp = ((t - p) > `ALHG_RAMP_STEP) ? p + `ALHG_RAMP_STEP : t;
    else
      ramp = p;
  endfunction

  assign period_d = ramp(period_q, tgt_per_i);
  assign floor_o  = (period_q >= `ALHG_START_PER);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_q <= `ALHG_START_PER;
      cnt_q    <= `ALHG_START_PER;
      step_o   <= 1'b0;
    end else if (!run_i) begin
      period_q <= `ALHG_START_PER;
      cnt_q    <= `ALHG_START_PER;
      step_o   <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      period_q <= period_d;
      cnt_q    <= period_d;
      step_o   <= 1'b1;
    end else begin
      cnt_q    <= cnt_q - 16'h0001;
      step_o   <= 1'b0;
    end
  end

endmodule // alhg_pulse_gen

// ==== design/alhg_top.sv ====
// Axis limit and home guard: AXI4-Lite registers, jog and home sequencing, position counter
//
// How it works
// - Elapsed position loads as two 16-bit words while idle
// - Jog into active limit refused, error raised
// - Limit during jog: ramped stop plus error
// - Captured limit inputs readable as flags
// - Limit polarity chosen by control field
// - Home and near-home polarity each configurable
// - Near-home starts deceleration to home speed
// - Indicator lit while home/near-home asserted
// - Direction setting maps motion to CW/CCW
// - Home return completion zeroes the counter
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "alhg_defs.svh"
module alhg_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        lim_pos_i,
  input  wire logic        lim_neg_i,
  input  wire logic        home_i,
  input  wire logic        near_home_i,
  output logic             cw_pulse_o,
  output logic             ccw_pulse_o,
  output logic             home_led_o,
  output logic             near_led_o,
  output logic             irq_o
);

  logic [7:0]            awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  wr_fire;
  logic [3:0]            ctrl_q;
  logic [15:0]           elap_lo_q;
  logic [31:0]           elapsed_q;
  logic [15:0]           jog_per_q;
  logic [15:0]           home_per_q;
  logic [3:0]            irq_stat_q;
  logic [3:0]            irq_mask_q;
  logic [3:0]            events;
  logic [3:0]            pins_s;
  logic [3:0]            act_q;
  logic                  lim_pos_act;
  logic                  lim_neg_act;
  logic                  home_act;
  logic                  near_act;
  alhg_pkg::alhg_state_t state_q;
  logic                  fwd_q;
  logic                  busy;
  logic                  run;
  logic [15:0]           tgt_per;
  logic                  step;
  logic                  floor;
  logic                  cmd_fwd;
  logic                  cmd_rev;
  logic                  cmd_home;
  logic                  cmd_stop;
  logic                  dir_lim;
  logic                  home_hit;

  // True for every mapped register offset
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `ALHG_OFF_CTRL, `ALHG_OFF_CMD, `ALHG_OFF_STATUS, `ALHG_OFF_ELAP_LO,
      `ALHG_OFF_ELAP_HI, `ALHG_OFF_JOG_PER, `ALHG_OFF_HOME_PER,
      `ALHG_OFF_IRQ_STAT, `ALHG_OFF_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Byte-lane merge of write data into a register's old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic hit(input logic [7:0] off);
    hit = wr_fire && (awaddr_q == off);
  endfunction

  // AXI4-Lite write channel: address and data accepted in either order
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ALHG_RESP_OKAY;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wready && s_axi_wvalid) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? `ALHG_RESP_OKAY : `ALHG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel, one cycle after the address is taken
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ALHG_RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped({s_axi_araddr[7:2], 2'b00}) ? `ALHG_RESP_OKAY
                                                          : `ALHG_RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        `ALHG_OFF_CTRL:     s_axi_rdata <= {28'h0000000, ctrl_q};
        `ALHG_OFF_STATUS:   s_axi_rdata <= {24'h000000, state_q, fwd_q, act_q};
        `ALHG_OFF_ELAP_LO:  s_axi_rdata <= {16'h0000, elapsed_q[15:0]};
        `ALHG_OFF_ELAP_HI:  s_axi_rdata <= {16'h0000, elapsed_q[31:16]};
        `ALHG_OFF_JOG_PER:  s_axi_rdata <= {16'h0000, jog_per_q};
        `ALHG_OFF_HOME_PER: s_axi_rdata <= {16'h0000, home_per_q};
        `ALHG_OFF_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat_q};
        `ALHG_OFF_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask_q};
        default:            s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q     <= `ALHG_CTRL_RST;
      jog_per_q  <= `ALHG_JOG_PER_RST;
      home_per_q <= `ALHG_HOME_PER_RST;
      irq_mask_q <= 4'h0;
    end else begin
      if (hit(`ALHG_OFF_CTRL))
        ctrl_q <= 4'(merge({28'h0000000, ctrl_q}, wdata_q, wstrb_q));
      if (hit(`ALHG_OFF_JOG_PER))
        jog_per_q <= 16'(merge({16'h0000, jog_per_q}, wdata_q, wstrb_q));
      if (hit(`ALHG_OFF_HOME_PER))
        home_per_q <= 16'(merge({16'h0000, home_per_q}, wdata_q, wstrb_q));
      if (hit(`ALHG_OFF_IRQ_MASK))
        irq_mask_q <= 4'(merge({28'h0000000, irq_mask_q}, wdata_q, wstrb_q));
    end
  end

  // Commands are one-cycle strobes from a write to the command offset
  // Decode spelled out: an assign wakes only on its own operands
  assign cmd_fwd  = wr_fire && (awaddr_q == `ALHG_OFF_CMD) && wdata_q[`ALHG_CMD_JOG_FWD];
  assign cmd_rev  = wr_fire && (awaddr_q == `ALHG_OFF_CMD) && wdata_q[`ALHG_CMD_JOG_REV];
  assign cmd_home = wr_fire && (awaddr_q == `ALHG_OFF_CMD) && wdata_q[`ALHG_CMD_HOME];
  assign cmd_stop = wr_fire && (awaddr_q == `ALHG_OFF_CMD) && wdata_q[`ALHG_CMD_STOP];

  // Switch inputs, synchronised then polarity-corrected
  alhg_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({near_home_i, home_i, lim_neg_i, lim_pos_i}),
    .sync_o     (pins_s)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_q <= 4'h0;
    end else begin
      act_q[0] <= pins_s[0] ^ ctrl_q[`ALHG_CTRL_LIM_INV];
      act_q[1] <= pins_s[1] ^ ctrl_q[`ALHG_CTRL_LIM_INV];
      act_q[2] <= pins_s[2] ^ ctrl_q[`ALHG_CTRL_HOME_INV];
      act_q[3] <= pins_s[3] ^ ctrl_q[`ALHG_CTRL_NEAR_INV];
    end
  end

  assign lim_pos_act = act_q[0];
  assign lim_neg_act = act_q[1];
  assign home_act    = act_q[2];
  assign near_act    = act_q[3];

  // Only the limit ahead of the travel matters
  assign dir_lim  = fwd_q ? lim_pos_act : lim_neg_act;
  assign busy     = (state_q != alhg_pkg::ALHG_IDLE);
  assign run      = busy;
  assign home_hit = (state_q == alhg_pkg::ALHG_HOME_SLOW) && home_act;

  always_comb begin
    case (state_q)
      alhg_pkg::ALHG_RUN,
      alhg_pkg::ALHG_HOME_FAST: tgt_per = jog_per_q;
      alhg_pkg::ALHG_HOME_SLOW: tgt_per = home_per_q;
      default:                  tgt_per = `ALHG_START_PER;
    endcase
  end

  alhg_pulse_gen u_gen (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (run),
    .tgt_per_i  (tgt_per),
    .step_o     (step),
    .floor_o    (floor)
  );

  // Motion sequencer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= alhg_pkg::ALHG_IDLE;
      fwd_q   <= 1'b1;
    end else begin
      case (state_q)
        alhg_pkg::ALHG_IDLE: begin
          if (cmd_fwd && !lim_pos_act) begin
            state_q <= alhg_pkg::ALHG_RUN;
            fwd_q   <= 1'b1;
          end else if (cmd_rev && !lim_neg_act) begin
            state_q <= alhg_pkg::ALHG_RUN;
            fwd_q   <= 1'b0;
          end else if (cmd_home && !lim_neg_act) begin
            state_q <= alhg_pkg::ALHG_HOME_FAST;
            fwd_q   <= 1'b0;
          end
        end
        alhg_pkg::ALHG_RUN: begin
          if (dir_lim || cmd_stop)
            state_q <= alhg_pkg::ALHG_DECEL;
        end
        alhg_pkg::ALHG_HOME_FAST: begin
          if (dir_lim || cmd_stop)
            state_q <= alhg_pkg::ALHG_DECEL;
          else if (near_act)
            state_q <= alhg_pkg::ALHG_HOME_SLOW;
        end
        alhg_pkg::ALHG_HOME_SLOW: begin
          if (home_act)
            state_q <= alhg_pkg::ALHG_IDLE;
          else if (dir_lim || cmd_stop)
            state_q <= alhg_pkg::ALHG_DECEL;
        end
        alhg_pkg::ALHG_DECEL: begin
          // Ramp back to start speed before the train halts
          if (step && floor)
            state_q <= alhg_pkg::ALHG_IDLE;
        end
        default: state_q <= alhg_pkg::ALHG_IDLE;
      endcase
    end
  end

  // Events for the interrupt status
  always_comb begin
    events = 4'h0;
    events[`ALHG_EV_START_ERR] = !busy && ((cmd_fwd && lim_pos_act) ||
                                 (!cmd_fwd && cmd_rev && lim_neg_act) ||
                                 (!cmd_fwd && !cmd_rev && cmd_home && lim_neg_act));
    events[`ALHG_EV_RUN_ERR]   = (state_q == alhg_pkg::ALHG_RUN ||
                                  state_q == alhg_pkg::ALHG_HOME_FAST ||
                                  (state_q == alhg_pkg::ALHG_HOME_SLOW && !home_act))
                                 && dir_lim;
    events[`ALHG_EV_HOME_DONE] = home_hit;
    events[`ALHG_EV_MOVE_DONE] = (state_q == alhg_pkg::ALHG_DECEL) && step && floor;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= 4'h0;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(hit(`ALHG_OFF_IRQ_STAT) ? wdata_q[3:0] : 4'h0)) | events;
      irq_o      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Elapsed-position counter; low word staged, high word write while idle commits both
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      elap_lo_q <= 16'h0000;
      elapsed_q <= 32'h0000_0000;
    end else begin
      if (hit(`ALHG_OFF_ELAP_LO))
        elap_lo_q <= wdata_q[15:0];
      if (home_hit)
        elapsed_q <= 32'h0000_0000;
      else if (hit(`ALHG_OFF_ELAP_HI) && !busy)
        elapsed_q <= {wdata_q[15:0], elap_lo_q};
      else if (step)
        elapsed_q <= fwd_q ? elapsed_q + 32'h0000_0001 : elapsed_q - 32'h0000_0001;
    end
  end

  // Pin outputs and indicators
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cw_pulse_o  <= 1'b0;
      ccw_pulse_o <= 1'b0;
      home_led_o  <= 1'b0;
      near_led_o  <= 1'b0;
    end else begin
      cw_pulse_o  <= step && (fwd_q ^ ctrl_q[`ALHG_CTRL_DIR_SWAP]);
      ccw_pulse_o <= step && !(fwd_q ^ ctrl_q[`ALHG_CTRL_DIR_SWAP]);
      home_led_o  <= home_act;
      near_led_o  <= near_act;
    end
  end

endmodule // alhg_top

// ==== tb/alhg_properties.sv ====
// Port-level checks on the axis limit and home guard
`timescale 1ns/1ps
module alhg_properties (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cw_pulse_o,
  input wire logic        ccw_pulse_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_w_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after acceptance");
  a_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_w_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted early");
  a_b_clear: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_resp_code: assert property (
    s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("illegal write response");
  a_dir_excl: assert property (
    !(cw_pulse_o && ccw_pulse_o))
    else $error("both step outputs high");

  c_cw: cover property (cw_pulse_o);
  c_ccw: cover property (ccw_pulse_o);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // alhg_properties

bind alhg_top alhg_properties i_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cw_pulse_o(cw_pulse_o), .ccw_pulse_o(ccw_pulse_o));

// ==== tb/alhg_axis_model.sv ====
// Stepped axis with limit, home and near-home switch contacts
`timescale 1ns/1ps
module alhg_axis_model #(
  parameter int START_POS = 5,
  parameter int NEAR_POS  = 3,
  parameter int HOME_POS  = 1
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic cw_i,
  input  wire logic ccw_i,
  input  wire logic lim_pos_on_i,
  input  wire logic lim_neg_on_i,
  input  wire logic sw_inv_i,
  output logic      lim_pos_o,
  output logic      lim_neg_o,
  output logic      home_o,
  output logic      near_home_o
);
  int pos_q;

  // Clockwise counts as the positive direction
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_q <= START_POS;
    end else if (cw_i) begin
      pos_q <= pos_q + 1;
    end else if (ccw_i) begin
      pos_q <= pos_q - 1;
    end
  end

  // Near-home dog stays made over the home point
  assign lim_pos_o   = lim_pos_on_i ^ sw_inv_i;
  assign lim_neg_o   = lim_neg_on_i ^ sw_inv_i;
  assign home_o      = (pos_q <= HOME_POS) ^ sw_inv_i;
  assign near_home_o = (pos_q <= NEAR_POS) ^ sw_inv_i;
endmodule // alhg_axis_model

// ==== tb/tb.sv ====
// Self-checking bench for the axis limit and home guard
`timescale 1ns/1ps
`include "alhg_defs.svh"
module tb;
  logic        core_clk_i;
  logic        rst_n_i = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awrdy, wrdy, bvld, arrdy, rvld;
  logic        lp, ln, hm, nh, cw, ccw, hled, nled, irq;
  logic        lp_on = 1'b0, ln_on = 1'b0, sinv = 1'b0;
  int          err_total, compares, ncw, nccw;

  alhg_top i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvld), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rready),
    .lim_pos_i(lp), .lim_neg_i(ln), .home_i(hm), .near_home_i(nh),
    .cw_pulse_o(cw), .ccw_pulse_o(ccw), .home_led_o(hled), .near_led_o(nled),
    .irq_o(irq));

  alhg_axis_model i_axis (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .cw_i(cw), .ccw_i(ccw), .lim_pos_on_i(lp_on), .lim_neg_on_i(ln_on),
    .sw_inv_i(sinv), .lim_pos_o(lp), .lim_neg_o(ln), .home_o(hm), .near_home_o(nh));

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (cw) ncw <= ncw + 1;
    if (ccw) nccw <= nccw + 1;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Channels released one by one, each at the edge that took it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    @(posedge core_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge core_clk_i);
      ta = pa & awrdy;
      tw = pw & wrdy;
      @(posedge core_clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    do @(negedge core_clk_i); while (bvld !== 1'b1);
    rsp = bresp;
    @(posedge core_clk_i);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge core_clk_i); while (arrdy !== 1'b1);
    @(posedge core_clk_i);
    arvalid <= 1'b0;
    do @(negedge core_clk_i); while (rvld !== 1'b1);
    rdv = rdata;
    rsp = rresp;
    @(posedge core_clk_i);
    rready <= 1'b0;
  endtask

  // No local cap: a hang runs into the watchdog, which counts it
  task automatic idle_wait(output logic slow);
    slow = 1'b0;
    do begin
      rd(`ALHG_OFF_STATUS);
      if (rdv[7:5] === 3'h4) slow = 1'b1;
    end while (rdv[7:5] !== 3'h0);
  endtask

  task automatic steps(input int k);
    int base;
    base = ncw + nccw;
    while (ncw + nccw < base + k) @(posedge core_clk_i);
  endtask

  // Switch inputs pass three flops before they count
  task automatic pins(input logic p, input logic q, input logic v);
    @(posedge core_clk_i);
    lp_on <= p;
    ln_on <= q;
    sinv <= v;
    repeat (6) @(posedge core_clk_i);
  endtask

  task automatic print_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk_i);
    err_total++;
    print_verdict();
  end

  initial begin
    logic slow, x;
    int c0, c1;
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(`ALHG_OFF_CTRL);
    chk(rdv, 32'h0);
    rd(8'h40);
    chk(32'(rsp), 32'h2);
    wr(8'h40, 32'hFFFF_FFFF);
    chk(32'(rsp), 32'h2);
    $display("registers done");
    wr(`ALHG_OFF_ELAP_LO, 32'h0000_1234);
    rd(`ALHG_OFF_ELAP_LO);
    chk(32'(rdv[15:0]), 32'h0);
    wr(`ALHG_OFF_ELAP_HI, 32'h0000_ABCD);
    rd(`ALHG_OFF_ELAP_LO);
    chk(32'(rdv[15:0]), 32'h1234);
    rd(`ALHG_OFF_ELAP_HI);
    chk(32'(rdv[15:0]), 32'hABCD);
    $display("elapsed load done");
    for (int i = 0; i < 4; i++) begin
      x = i[0] ^ i[1];
      wr(`ALHG_OFF_CTRL, i[0] ? 32'h7 : 32'h0);
      pins(1'b1, 1'b0, i[1]);
      rd(`ALHG_OFF_STATUS);
      chk(32'(rdv[3:0]), {28'h0, x, x, x, ~x});
      chk(32'({hled, nled}), {30'h0, x, x});
    end
    wr(`ALHG_OFF_CTRL, 32'h0);
    pins(1'b1, 1'b0, 1'b0);
    $display("polarity done");
    wr(`ALHG_OFF_CMD, 32'h1);
    rd(`ALHG_OFF_STATUS);
    chk(32'(rdv[7:5]), 32'h0);
    rd(`ALHG_OFF_IRQ_STAT);
    chk(rdv, 32'h1);
    chk(32'(irq), 32'h0);
    wr(`ALHG_OFF_IRQ_MASK, 32'hF);
    repeat (2) @(posedge core_clk_i);
    chk(32'(irq), 32'h1);
    wr(`ALHG_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk_i);
    chk(32'(irq), 32'h0);
    $display("refused start done");
    pins(1'b0, 1'b0, 1'b0);
    wr(`ALHG_OFF_CMD, 32'h4);
    idle_wait(slow);
    chk(32'(slow), 32'h1);
    rd(`ALHG_OFF_ELAP_LO);
    chk(32'(rdv[15:0]), 32'h0);
    rd(`ALHG_OFF_ELAP_HI);
    chk(32'(rdv[15:0]), 32'h0);
    rd(`ALHG_OFF_IRQ_STAT);
    chk(rdv, 32'h4);
    chk(32'(hled), 32'h1);
    wr(`ALHG_OFF_IRQ_STAT, 32'hF);
    $display("home return done");
    wr(`ALHG_OFF_CTRL, 32'h8);
    pins(1'b1, 1'b0, 1'b0);
    c0 = ncw;
    c1 = nccw;
    wr(`ALHG_OFF_CMD, 32'h2);
    steps(1);
    chk(32'(ncw - c0), 32'h1);
    chk(32'(nccw - c1), 32'h0);
    wr(`ALHG_OFF_CMD, 32'h8);
    idle_wait(slow);
    rd(`ALHG_OFF_IRQ_STAT);
    chk(rdv, 32'h8);
    wr(`ALHG_OFF_IRQ_STAT, 32'hF);
    wr(`ALHG_OFF_CTRL, 32'h0);
    $display("reverse jog done");
    pins(1'b0, 1'b1, 1'b0);
    wr(`ALHG_OFF_JOG_PER, 32'h0FE0);
    c0 = ncw;
    wr(`ALHG_OFF_CMD, 32'h1);
    steps(3);
    chk(32'(ncw - c0), 32'h3);
    pins(1'b1, 1'b1, 1'b0);
    c0 = ncw;
    idle_wait(slow);
    chk(32'(ncw > c0), 32'h1);
    rd(`ALHG_OFF_IRQ_STAT);
    chk(32'(rdv[1]), 32'h1);
    $display("limit stop done");
    print_verdict();
  end
endmodule // tb
